//--- verilog/tio_pkg.sv
// Notes on behaviour
// - Timer output rises when counter equals compare.
// - Output holds until software writes compare.
// - Output pin always equals timer pending bit.
// - Non-external mode: timer fed back on input.
// - Merge by mux or OR, usually input 5.
// - Static select pins name the timer input.
// - External controller ranks timer among sources.
// - External controller drives encoded level on inputs.
// - External mode: core ignores static select pins.
package tio_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned TIO_DATA_W = 32;   // Bus and counter width
  localparam int unsigned TIO_ADDR_W = 5;    // Byte address width
  localparam int unsigned TIO_HWI_N  = 6;    // Hardware interrupt inputs
  localparam int unsigned TIO_SEL_W  = 3;    // Timer input select width

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] TIO_OFF_COUNT   = 5'h00;  // Free-running counter
  localparam logic [4:0] TIO_OFF_COMPARE = 5'h04;  // Compare, write clears pending
  localparam logic [4:0] TIO_OFF_CAUSE   = 5'h08;  // Cause/status mirror
  localparam logic [4:0] TIO_OFF_STATUS  = 5'h0c;  // Sticky events, read clears
  localparam logic [4:0] TIO_OFF_MASK    = 5'h10;  // Event mask
  localparam logic [4:0] TIO_OFF_CTRL    = 5'h14;  // Control

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned TIO_CAUSE_PEND_BIT  = 0;   // Timer pending bit
  localparam int unsigned TIO_CAUSE_TAKEN_BIT = 1;   // Timer seen on inputs
  localparam int unsigned TIO_CAUSE_HWI_LSB   = 8;   // Hardware inputs [13:8]
  localparam int unsigned TIO_CAUSE_SEL_LSB   = 16;  // Select [18:16]
  localparam int unsigned TIO_CAUSE_EIC_BIT   = 20;  // External controller mode
  localparam int unsigned TIO_EV_MATCH_BIT    = 0;   // Event: compare match
  localparam int unsigned TIO_EV_TAKEN_BIT    = 1;   // Event: timer reached core
  localparam int unsigned TIO_EV_N            = 2;   // Number of events
  localparam int unsigned TIO_CTRL_EN_BIT     = 0;   // Counter run enable

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] TIO_COUNT_RST   = 32'h0000_0000;
  localparam logic [31:0] TIO_COMPARE_RST = 32'hffff_ffff;
  localparam logic [1:0]  TIO_MASK_RST    = 2'h0;
  localparam logic        TIO_CTRL_EN_RST = 1'b1;
  localparam logic [3:0]  TIO_COUNT_DIV   = 4'h2;   // Core cycles per count
  localparam logic [2:0]  TIO_SEL_DEFAULT = 3'h5;   // Customary timer input
  localparam logic [2:0]  TIO_TIMER_LEVEL = 3'h7;   // Timer rank, controller mode

endpackage

//--- verilog/tio_link_if.sv
`timescale 1ns/100ps
// --------------------------------------------------------------------
// Timer interrupt link between core and system interrupt logic
// --------------------------------------------------------------------
interface tio_link_if;
  import tio_pkg::*;

  logic                 timer_irq_out;                  // Core timer interrupt
  logic [TIO_HWI_N-1:0] hw_irq_in;                      // Hardware inputs or level
  logic [TIO_SEL_W-1:0] timer_irq_input_select;         // Static timer input index
  logic                 external_irq_controller_mode;   // Static mode strap

  // Core end
  modport core (
    output timer_irq_out,
    input  hw_irq_in,
    input  timer_irq_input_select,
    input  external_irq_controller_mode
  );

  // System interrupt logic end
  modport router (
    input  timer_irq_out,
    output hw_irq_in,
    output timer_irq_input_select,
    output external_irq_controller_mode
  );

endinterface

//--- verilog/tio_irq_router.sv
`timescale 1ns/100ps
// --------------------------------------------------------------------
// System side: routes the timer interrupt back into the core
// --------------------------------------------------------------------
module tio_irq_router (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  // Link to core
  tio_link_if.router                        link,
  // Other interrupt sources
  input  wire logic [tio_pkg::TIO_HWI_N-1:0] sys_irq,
  // Static configuration
  input  wire logic                         eic_mode_cfg,
  input  wire logic                         merge_or_cfg,
  input  wire logic [tio_pkg::TIO_SEL_W-1:0] timer_input_cfg
);
  import tio_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [TIO_HWI_N-1:0] hwi_reg,  hwi_next;    // Driven hardware inputs
  logic [TIO_SEL_W-1:0] sel_reg,  sel_next;    // Select strap
  logic                 eic_reg,  eic_next;    // Mode strap

  // Highest active level among sources, timer ranked at its own level
  function automatic logic [TIO_HWI_N-1:0] rank(input logic [TIO_HWI_N-1:0] src,
                                                input logic               tmr);
    logic [TIO_HWI_N-1:0] lvl;
    lvl = '0;
    for (int i = 0; i < TIO_HWI_N; i++) begin
      if (src[i]) begin
        lvl = TIO_HWI_N'(i + 1);
      end
    end
    if (tmr && (lvl < TIO_HWI_N'(TIO_TIMER_LEVEL))) begin
      lvl = TIO_HWI_N'(TIO_TIMER_LEVEL);
    end
    return lvl;
  endfunction

  // ------------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------------
  always_comb begin
    sel_next = timer_input_cfg;
    eic_next = eic_mode_cfg;
    hwi_next = sys_irq;
    if (eic_reg) begin
      // Encoded level replaces individual lines
      hwi_next = rank(sys_irq, link.timer_irq_out);
    end else begin
      for (int i = 0; i < TIO_HWI_N; i++) begin
        if (TIO_SEL_W'(i) == sel_reg) begin
          // Mux by default, OR when so configured
          hwi_next[i] = merge_or_cfg ? (sys_irq[i] | link.timer_irq_out)
                                     : link.timer_irq_out;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hwi_reg <= '0;
      sel_reg <= TIO_SEL_DEFAULT;
      eic_reg <= 1'b0;
    end else begin
      hwi_reg <= hwi_next;
      sel_reg <= sel_next;
      eic_reg <= eic_next;
    end
  end

  // Every link output comes from a flop
  assign link.hw_irq_in                    = hwi_reg;
  assign link.timer_irq_input_select       = sel_reg;
  assign link.external_irq_controller_mode = eic_reg;

endmodule

//--- verilog/tio_core_timer.sv
`timescale 1ns/100ps
// --------------------------------------------------------------------
// Core end: counter, compare, timer interrupt, register slave
// --------------------------------------------------------------------
module tio_core_timer (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  // Link to system interrupt logic
  tio_link_if.core                           link,
  // Avalon-MM slave
  input  wire logic [tio_pkg::TIO_ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [tio_pkg::TIO_DATA_W-1:0] avs_writedata,
  output logic      [tio_pkg::TIO_DATA_W-1:0] avs_readdata,
  output logic                               avs_waitrequest,
  // Interrupt to software
  output logic                               irq
);
  import tio_pkg::*;

  // ------------------------------------------------------------------
  // Bus handshake state
  // ------------------------------------------------------------------
  logic                  wait_reg,  wait_next;    // Waitrequest, high at idle
  logic [TIO_DATA_W-1:0] rdata_reg, rdata_next;   // Read data holding flop
  logic                  req;                     // Any request present
  logic                  acc;                     // Request completes this edge
  logic                  wr_acc;                  // Write takes effect
  logic                  rd_acc;                  // Read completes

  // ------------------------------------------------------------------
  // Timer state
  // ------------------------------------------------------------------
  logic [TIO_DATA_W-1:0] count_reg,   count_next;     // Free-running counter
  logic [TIO_DATA_W-1:0] compare_reg, compare_next;   // Compare value
  logic                  pend_reg,    pend_next;      // Timer pending bit
  logic [3:0]            div_reg,     div_next;       // Count rate divider
  logic                  tick;                        // Count enable pulse
  logic                  en_reg,      en_next;        // Counter run enable
  logic                  match;                       // Counter equals compare

  // ------------------------------------------------------------------
  // Feedback and event state
  // ------------------------------------------------------------------
  logic                  taken;                       // Timer seen at the inputs
  logic                  taken_reg,   taken_next;     // Last value of taken
  logic [TIO_EV_N-1:0]   stat_reg,    stat_next;      // Sticky event bits
  logic [TIO_EV_N-1:0]   mask_reg,    mask_next;      // Event mask
  logic [TIO_EV_N-1:0]   ev_set;                      // Events this cycle
  logic                  irq_reg,     irq_next;       // Interrupt output flop

  // Decode a register offset from the byte address
  function automatic logic hit(input logic [TIO_ADDR_W-1:0] a,
                               input logic [4:0]            off);
    return a == off;
  endfunction

  // ------------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------------
  // A request is answered in the cycle after it appears; the write
  // acts on the edge where the master sees waitrequest low.
  assign req    = avs_read | avs_write;
  assign acc    = req & ~wait_reg;
  assign wr_acc = acc & avs_write;
  assign rd_acc = acc & avs_read;

  // ------------------------------------------------------------------
  // Match and feedback detection
  // ------------------------------------------------------------------
  // Evaluated every core cycle against registered values
  assign match = (count_reg == compare_reg);

  // Divider gives a one-cycle count pulse every TIO_COUNT_DIV cycles
  assign tick  = (div_reg == (TIO_COUNT_DIV - 4'h1));

  // In controller mode the inputs carry a level, so the select pins
  // mean nothing and any nonzero level counts as delivery.
  always_comb begin
    taken = 1'b0;
    if (link.external_irq_controller_mode) begin
      taken = |link.hw_irq_in;
    end else begin
      for (int i = 0; i < TIO_HWI_N; i++) begin
        if (TIO_SEL_W'(i) == link.timer_irq_input_select) begin
          taken = link.hw_irq_in[i] & pend_reg;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Timer next values
  // ------------------------------------------------------------------
  always_comb begin
    count_next   = count_reg;
    compare_next = compare_reg;
    pend_next    = pend_reg;
    en_next      = en_reg;
    div_next     = tick ? 4'h0 : div_reg + 4'h1;
    // Counter runs when enabled; software write overrides the step
    if (en_reg && tick) begin
      count_next = count_reg + 32'h0000_0001;
    end
    if (wr_acc && hit(avs_address, TIO_OFF_COUNT)) begin
      count_next = avs_writedata;
    end
    if (wr_acc && hit(avs_address, TIO_OFF_CTRL)) begin
      en_next = avs_writedata[TIO_CTRL_EN_BIT];
    end
    // Pending sets on match, sticks, and falls only on compare write.
    // The compare write wins a tie so software can always retire it.
    if (match) begin
      pend_next = 1'b1;
    end
    if (wr_acc && hit(avs_address, TIO_OFF_COMPARE)) begin
      compare_next = avs_writedata;
      pend_next    = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Event, mask and interrupt next values
  // ------------------------------------------------------------------
  always_comb begin
    ev_set                   = '0;
    ev_set[TIO_EV_MATCH_BIT] = match & ~pend_reg;
    ev_set[TIO_EV_TAKEN_BIT] = taken & ~taken_reg;
    taken_next               = taken;
    mask_next                = mask_reg;
    stat_next                = stat_reg;
    if (wr_acc && hit(avs_address, TIO_OFF_MASK)) begin
      mask_next = avs_writedata[TIO_EV_N-1:0];
    end
    // Read clears, but a new event in the same cycle survives
    if (rd_acc && hit(avs_address, TIO_OFF_STATUS)) begin
      stat_next = '0;
    end
    stat_next = stat_next | ev_set;
    irq_next  = |(stat_reg & mask_reg);
  end

  // ------------------------------------------------------------------
  // Bus next values
  // ------------------------------------------------------------------
  always_comb begin
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    if (req && wait_reg) begin
      // Drop waitrequest for exactly one cycle
      wait_next  = 1'b0;
      rdata_next = '0;
      if (avs_read) begin
        unique case (avs_address)
          TIO_OFF_COUNT:   rdata_next = count_reg;
          TIO_OFF_COMPARE: rdata_next = compare_reg;
          TIO_OFF_CAUSE: begin
            rdata_next[TIO_CAUSE_PEND_BIT]  = pend_reg;
            rdata_next[TIO_CAUSE_TAKEN_BIT] = taken;
            rdata_next[TIO_CAUSE_HWI_LSB +: TIO_HWI_N] = link.hw_irq_in;
            rdata_next[TIO_CAUSE_EIC_BIT]   = link.external_irq_controller_mode;
            // Select reads as zero where it carries no meaning
            if (!link.external_irq_controller_mode) begin
              rdata_next[TIO_CAUSE_SEL_LSB +: TIO_SEL_W] =
                link.timer_irq_input_select;
            end
          end
          TIO_OFF_STATUS:  rdata_next[TIO_EV_N-1:0] = stat_reg;
          TIO_OFF_MASK:    rdata_next[TIO_EV_N-1:0] = mask_reg;
          TIO_OFF_CTRL:    rdata_next[TIO_CTRL_EN_BIT] = en_reg;
          // Unmapped addresses read as zero
          default:         rdata_next = '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg    <= 1'b1;
      rdata_reg   <= '0;
      count_reg   <= TIO_COUNT_RST;
      compare_reg <= TIO_COMPARE_RST;
      pend_reg    <= 1'b0;
      div_reg     <= 4'h0;
      en_reg      <= TIO_CTRL_EN_RST;
      taken_reg   <= 1'b0;
      stat_reg    <= '0;
      mask_reg    <= TIO_MASK_RST;
      irq_reg     <= 1'b0;
    end else begin
      wait_reg    <= wait_next;
      rdata_reg   <= rdata_next;
      count_reg   <= count_next;
      compare_reg <= compare_next;
      pend_reg    <= pend_next;
      div_reg     <= div_next;
      en_reg      <= en_next;
      taken_reg   <= taken_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      irq_reg     <= irq_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Pin and cause field come from the same flop, so they never differ
  assign link.timer_irq_out = pend_reg;
  assign avs_readdata       = rdata_reg;
  assign avs_waitrequest    = wait_reg;
  assign irq                = irq_reg;

endmodule

//--- tb/tio_link_properties.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Link properties between core timer and interrupt router
// ------------------------------------------------------------
module tio_link_properties (
  // Clock and reset
  input wire logic                            ref_clk,
  input wire logic                            rst_n,
  // Link signals, watched only
  input wire logic                            timer_irq_out,
  input wire logic [tio_pkg::TIO_HWI_N-1:0]   hw_irq_in,
  input wire logic [tio_pkg::TIO_SEL_W-1:0]   timer_irq_input_select,
  input wire logic                            external_irq_controller_mode
);
  import tio_pkg::*;

  // ------------------------------------------------------------
  // Sampling and named steps
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Timer pending while the router merges per line
  sequence s_tmr_normal;
    !external_irq_controller_mode && timer_irq_out;
  endsequence

  // Timer pending while levels are encoded
  sequence s_tmr_ctrl;
    external_irq_controller_mode && timer_irq_out;
  endsequence

  // Straps load at the first edge, so only judge them two edges on
  sequence s_settled;
    $past(rst_n) && $past(rst_n, 2);
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  chk_reset_quiet: assert property ($rose(rst_n) |-> !timer_irq_out [*3])
    else $error("timer output active right after reset");
  chk_mux_feedback: assert property (s_tmr_normal |=> hw_irq_in[timer_irq_input_select])
    else $error("timer not fed back on selected input");
  chk_sel_range: assert property (!external_irq_controller_mode |-> timer_irq_input_select <= 3'h5)
    else $error("select names no hardware input");
  chk_sel_static: assert property (s_settled |-> $stable(timer_irq_input_select))
    else $error("select moved while running");
  chk_mode_static: assert property (s_settled |-> $stable(external_irq_controller_mode))
    else $error("mode strap moved while running");
  chk_eic_level: assert property (s_tmr_ctrl |=> hw_irq_in == 6'h07)
    else $error("timer level not encoded on inputs");
  chk_eic_ceiling: assert property (external_irq_controller_mode && !timer_irq_out |=> hw_irq_in <= 6'h06)
    else $error("encoded level too high without timer");
  chk_eic_fall: assert property ($fell(timer_irq_out) ##0 external_irq_controller_mode |=> hw_irq_in != 6'h07)
    else $error("timer level held after timer cleared");

endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Self-checking bench for the timer interrupt link
// ------------------------------------------------------------
module tb_top;
  import tio_pkg::*;

  logic                  ref_clk;          // 40 MHz core clock
  logic                  rst_n;            // Active-low reset
  logic [TIO_ADDR_W-1:0] avs_address;      // Register byte address
  logic                  avs_read;         // Read strobe
  logic                  avs_write;        // Write strobe
  logic [TIO_DATA_W-1:0] avs_writedata;    // Write data
  logic [TIO_DATA_W-1:0] avs_readdata;     // Read data
  logic                  avs_waitrequest;  // Slave stall
  logic                  irq;              // Software interrupt
  logic [TIO_HWI_N-1:0]  sys_irq;          // Other interrupt sources
  logic                  eic_mode_cfg;     // Controller mode strap
  logic                  merge_or_cfg;     // OR instead of mux
  logic [TIO_SEL_W-1:0]  timer_input_cfg;  // Timer input index
  int                    mismatches;       // Failed comparisons
  int                    total_checks;     // All comparisons
  logic [31:0]           rd;               // Last read word
  logic [31:0]           x;                // Random count value

  tio_link_if link ();
  tio_core_timer tio_core_timer_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  tio_irq_router tio_irq_router_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .sys_irq(sys_irq), .eic_mode_cfg(eic_mode_cfg), .merge_or_cfg(merge_or_cfg),
    .timer_input_cfg(timer_input_cfg));
  tio_link_properties tio_link_properties_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .timer_irq_out(link.timer_irq_out), .hw_irq_in(link.hw_irq_in),
    .timer_irq_input_select(link.timer_irq_input_select),
    .external_irq_controller_mode(link.external_irq_controller_mode));

  // ------------------------------------------------------------
  // Clock, verdict and comparisons
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Word and vector results
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Single-line results
  task automatic chk_bit(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  // One Avalon transfer; holds everything until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk_bit(1'b1, 1'b0, "bus stalled");
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Expected values
  // ------------------------------------------------------------
  // Router output: encoded level, or per-line merge of the timer
  function automatic logic [5:0] exp_hw(input logic tmr);
    logic [5:0] v;
    int         lv;
    lv = tmr ? 7 : 0;
    if (eic_mode_cfg) begin
      for (int i = 0; i < 6; i++) if (sys_irq[i] && lv < i + 1) lv = i + 1;
      return 6'(lv);
    end
    v = sys_irq;
    v[timer_input_cfg] = merge_or_cfg ? (v[timer_input_cfg] | tmr) : tmr;
    return v;
  endfunction

  // Cause mirror; select reads zero when levels are encoded
  function automatic logic [31:0] exp_cause(input logic tmr);
    logic [5:0]  h;
    logic [31:0] c;
    h = exp_hw(tmr);
    c = '0;
    c[TIO_CAUSE_PEND_BIT]  = tmr;
    c[TIO_CAUSE_TAKEN_BIT] = eic_mode_cfg ? (h != 6'h0) : (h[timer_input_cfg] && tmr);
    c[13:8]                = h;
    c[18:16]               = eic_mode_cfg ? 3'h0 : timer_input_cfg;
    c[TIO_CAUSE_EIC_BIT]   = eic_mode_cfg;
    return c;
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Stopped counter, compare set equal: clear on write, set one edge on
  task automatic fire(input logic [31:0] v);
    bus(1'b1, TIO_OFF_CTRL, 32'h0);
    bus(1'b1, TIO_OFF_COUNT, v);
    bus(1'b1, TIO_OFF_COMPARE, v);
    #1 chk_bit(link.timer_irq_out, 1'b0, "pending not cleared by write");
    @(posedge ref_clk);
    #1 chk_bit(link.timer_irq_out, 1'b1, "match not flagged next edge");
    // Stopped counter must read back the value that made the match
    bus(1'b0, TIO_OFF_COUNT, 32'h0);
    chk_word(rd, v, "stopped count");
  endtask

  // Reset values, then a running counter crossing the compare value
  task automatic run_hold();
    int n = 0;
    bus(1'b0, TIO_OFF_CTRL, 32'h0);
    chk_word(rd, 32'h1, "ctrl reset");
    bus(1'b0, TIO_OFF_COMPARE, 32'h0);
    chk_word(rd, TIO_COMPARE_RST, "compare reset");
    bus(1'b0, TIO_OFF_MASK, 32'h0);
    chk_word(rd, 32'h0, "mask reset");
    bus(1'b0, 5'h18, 32'h0);
    chk_word(rd, 32'h0, "unmapped read");
    bus(1'b1, TIO_OFF_CTRL, 32'h0);
    x = $urandom;
    bus(1'b1, TIO_OFF_COUNT, x);
    bus(1'b1, TIO_OFF_COMPARE, x + 32'h2);
    repeat (8) @(posedge ref_clk);
    chk_bit(link.timer_irq_out, 1'b0, "output without match");
    bus(1'b1, TIO_OFF_CTRL, 32'h1);
    while (link.timer_irq_out !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    chk_bit(link.timer_irq_out, 1'b1, "no output on match");
    repeat (20) @(posedge ref_clk);
    chk_bit(link.timer_irq_out, 1'b1, "output dropped early");
    bus(1'b1, TIO_OFF_COMPARE, x + 32'h2);
    #1 chk_bit(link.timer_irq_out, 1'b0, "output kept after write");
    bus(1'b0, TIO_OFF_STATUS, 32'h0);
  endtask

  // Routing, cause mirror and event interrupt for the current straps
  task automatic run_phase();
    repeat (3) @(posedge ref_clk);
    chk_word(32'(link.hw_irq_in), 32'(exp_hw(1'b0)), "idle lines");
    bus(1'b0, TIO_OFF_CAUSE, 32'h0);
    chk_word(rd, exp_cause(1'b0), "cause idle");
    fire($urandom);
    repeat (3) @(posedge ref_clk);
    chk_word(32'(link.hw_irq_in), 32'(exp_hw(1'b1)), "timer lines");
    bus(1'b0, TIO_OFF_CAUSE, 32'h0);
    chk_word(rd, exp_cause(1'b1), "cause pending");
    chk_bit(rd[TIO_CAUSE_PEND_BIT], link.timer_irq_out, "pin and bit differ");
    bus(1'b1, TIO_OFF_MASK, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk_bit(irq, 1'b1, "irq not raised");
    bus(1'b0, TIO_OFF_STATUS, 32'h0);
    chk_word(rd, 32'h3, "status events");
    repeat (2) @(posedge ref_clk);
    chk_bit(irq, 1'b0, "irq not cleared");
    bus(1'b0, TIO_OFF_STATUS, 32'h0);
    chk_word(rd, 32'h0, "status not cleared");
    bus(1'b1, TIO_OFF_COMPARE, 32'h5);
    #1 chk_bit(link.timer_irq_out, 1'b0, "output kept after write");
    repeat (3) @(posedge ref_clk);
    chk_word(32'(link.hw_irq_in), 32'(exp_hw(1'b0)), "lines after clear");
  endtask

  // Watchdog: far beyond the few hundred cycles the four strap sets need
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end

  // Main sequence: default mux, random mux, OR merge, controller mode
  initial begin
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    sys_irq = '0;
    eic_mode_cfg = 1'b0;
    merge_or_cfg = 1'b0;
    timer_input_cfg = TIO_SEL_DEFAULT;
    mismatches = 0;
    total_checks = 0;
    x = $urandom(32'h9509ee95);
    for (int ph = 0; ph < 4; ph++) begin
      rst_n           <= 1'b0;
      eic_mode_cfg    <= (ph == 3);
      merge_or_cfg    <= (ph == 2);
      timer_input_cfg <= (ph == 0) ? TIO_SEL_DEFAULT : 3'($urandom_range(5));
      sys_irq         <= 6'($urandom);
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      if (ph == 0) run_hold();
      run_phase();
    end
    tally_and_finish();
  end

endmodule
